/* rtl/sdram_mode_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - mode registers keep contents until rewritten or reset; DLL reset bit self-clears
// - new settings apply after the update interval; DLL reset takes longer
// - on-the-fly mode: A12 low gives chop 4, high gives 8
// - burst wraps within aligned block set by upper column bits
// - ordering select chooses sequential or interleaved column order for reads; writes ignore it
// - sequential reads rotate within the nibble, then the other nibble
// - interleaved reads use start column XOR beat count
// - chop-4 reads drive four beats then release drivers for four slots
// - chop-4 writes use only bit 2; length-8 writes always 0 to 7
// - chop-4 bursts start internally at the same time as length-8
// - writing DLL reset bit starts DLL reset, bit clears itself
// - read latency field sets whole-cycle delay, 5 to 14
// - power-down DLL bit 0 stops DLL (slow exit), 1 keeps it
// - bank address bits pick the target mode register
module sdram_mode_ctrl
  import sdram_mode_pkg::*;
#(
  parameter int MOD_CYCLES = MOD_CYCLES_DEF,
  parameter int WRITE_LAT  = WRITE_LAT_DEF,
  parameter int COL_W      = 10
)
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // command pins
  input  wire cmd_pins_t           cmd_pins,
  // register state
  output logic [MR_W-1:0]          base_mode_register,
  output logic [OTHER_MRS-1:0][ADDR_W-1:0] other_mode_registers,
  output mode_fields_t             mode_fields,
  output logic                     settings_ready,
  // DLL
  output logic                     dll_reset_pulse,
  output logic                     dll_locked,
  output logic                     dll_off_in_powerdown,
  // burst beats
  output logic                     beat_valid,
  output logic [COL_W-1:0]         beat_col,
  output logic                     beat_active,
  output logic                     beat_dq_oe
);

  localparam int MOD_W  = $clog2(MOD_CYCLES + 1);
  localparam int DLLK_W = $clog2(DLLK_CYCLES + 1);
  localparam logic [MOD_W-1:0]  MOD_LOAD  = MOD_W'(MOD_CYCLES);
  localparam logic [DLLK_W-1:0] DLLK_LOAD = DLLK_W'(DLLK_CYCLES);
  localparam logic [LAT_W-1:0]  WLAT      = LAT_W'(WRITE_LAT);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BEATS} burst_state_t;

  // ----------------------------------------------------------------
  // pin synchroniser and command decode
  // ----------------------------------------------------------------
  cmd_pins_t pins_meta_reg;
  cmd_pins_t pins_reg;

  always_ff @(posedge clk)
  begin
    pins_meta_reg <= cmd_pins;
    pins_reg      <= pins_meta_reg;
  end

  logic is_mrs;
  logic is_read;
  logic is_write;

  assign is_mrs   = ~pins_reg.cs_n & ~pins_reg.ras_n & ~pins_reg.cas_n & ~pins_reg.we_n;
  assign is_read  = ~pins_reg.cs_n & pins_reg.ras_n & ~pins_reg.cas_n & pins_reg.we_n;
  assign is_write = ~pins_reg.cs_n & pins_reg.ras_n & ~pins_reg.cas_n & ~pins_reg.we_n;

  // ----------------------------------------------------------------
  // mode register storage
  // ----------------------------------------------------------------
  logic [MR_W-1:0]                  base_reg;
  logic [OTHER_MRS-1:0][ADDR_W-1:0] mr_other_reg;
  logic                             base_write;

  assign base_write = is_mrs & (pins_reg.ba == SEL_BASE);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      base_reg <= BASE_RESET;
    else if (base_write)
      base_reg <= {pins_reg.ba, pins_reg.addr};
    else if (base_reg[DLL_RST])
      base_reg[DLL_RST] <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mr_other_reg <= '0;
    else if (is_mrs && pins_reg.ba == SEL_MR1)
      mr_other_reg[0] <= pins_reg.addr;
    else if (is_mrs && pins_reg.ba == SEL_MR2)
      mr_other_reg[1] <= pins_reg.addr;
    else if (is_mrs && pins_reg.ba == SEL_MR3)
      mr_other_reg[2] <= pins_reg.addr;
  end

  assign base_mode_register   = base_reg;
  assign other_mode_registers = mr_other_reg;
  assign dll_reset_pulse      = base_reg[DLL_RST];

  // ----------------------------------------------------------------
  // mode-update interval: new fields take effect when it expires
  // ----------------------------------------------------------------
  logic [MOD_W-1:0] mod_cnt_reg;
  mode_fields_t     fields_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mod_cnt_reg <= '0;
    else if (is_mrs)
      mod_cnt_reg <= MOD_LOAD;
    else if (mod_cnt_reg != '0)
      mod_cnt_reg <= mod_cnt_reg - 1'b1;
  end

  // the update lands on the last counted cycle, so a burst accepted just
  // after settings_ready rises already sees the new fields
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fields_reg <= decode_fields(BASE_RESET);
    else if (mod_cnt_reg == MOD_W'(1))
      fields_reg <= decode_fields(base_reg);
  end

  assign settings_ready       = (mod_cnt_reg == '0);
  assign mode_fields          = fields_reg;
  assign dll_off_in_powerdown = ~fields_reg.precharge_powerdown_dll;

  // ----------------------------------------------------------------
  // DLL lock timer, longer than the update interval
  // ----------------------------------------------------------------
  logic [DLLK_W-1:0] dll_cnt_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dll_cnt_reg <= '0;
    else if (base_reg[DLL_RST])
      dll_cnt_reg <= DLLK_LOAD;
    else if (dll_cnt_reg != '0)
      dll_cnt_reg <= dll_cnt_reg - 1'b1;
  end

  assign dll_locked = (dll_cnt_reg == '0) & ~base_reg[DLL_RST];

  // ----------------------------------------------------------------
  // burst acceptance
  // ----------------------------------------------------------------
  burst_state_t        state_reg;
  logic [LAT_W-1:0]    lat_cnt_reg;
  logic [BEAT_W-1:0]   beat_idx_reg;
  logic [BEAT_W-1:0]   start_reg;
  logic [COL_W-1:0]    block_reg;
  logic                wr_reg;
  logic                chop_reg;
  logic                ilv_reg;
  logic                cmd_chop;
  logic [LAT_W-1:0]    cmd_lat;

  // chop decided per command in on-the-fly mode
  assign cmd_chop = (fields_reg.burst_length == BL_FIXED4) |
                    ((fields_reg.burst_length == BL_OTF) & ~pins_reg.addr[OTF_BIT]);
  // chop and length-8 share one start latency
  assign cmd_lat  = is_write ? WLAT : fields_reg.read_latency_cycles;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg    <= ST_IDLE;
      lat_cnt_reg  <= '0;
      beat_idx_reg <= '0;
      start_reg    <= '0;
      block_reg    <= '0;
      wr_reg       <= 1'b0;
      chop_reg     <= 1'b0;
      ilv_reg      <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // a new command while a burst runs is not accepted
          if (is_read || is_write)
          begin
            state_reg   <= ST_WAIT;
            lat_cnt_reg <= cmd_lat - 1'b1;
            start_reg   <= pins_reg.addr[BEAT_W-1:0];
            block_reg   <= pins_reg.addr[COL_W-1:0];
            wr_reg      <= is_write;
            chop_reg    <= cmd_chop;
            ilv_reg     <= fields_reg.burst_ordering_select;
          end
        end
        ST_WAIT:
        begin
          lat_cnt_reg <= lat_cnt_reg - 1'b1;
          if (lat_cnt_reg == LAT_W'(1))
          begin
            state_reg    <= ST_BEATS;
            beat_idx_reg <= BEAT_W'(1);
          end
        end
        ST_BEATS:
        begin
          beat_idx_reg <= beat_idx_reg + 1'b1;
          if (beat_idx_reg == LAST_BEAT)
            state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // beat outputs
  // ----------------------------------------------------------------
  logic [BEAT_W-1:0] cur_beat;
  logic [BEAT_W-1:0] low_col;
  logic              emit;
  logic              slot_used;

  assign emit      = ((state_reg == ST_WAIT) && (lat_cnt_reg == LAT_W'(1))) ||
                     (state_reg == ST_BEATS);
  assign cur_beat  = (state_reg == ST_BEATS) ? beat_idx_reg : '0;
  assign slot_used = ~chop_reg | ~cur_beat[NIBBLE_BIT];

  burst_col_order u_order (
    .start_col  (start_reg),
    .interleave (ilv_reg),
    .is_write   (wr_reg),
    .chop4      (chop_reg),
    .beat       (cur_beat),
    .col        (low_col)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      beat_valid  <= 1'b0;
      beat_col    <= '0;
      beat_active <= 1'b0;
      beat_dq_oe  <= 1'b0;
    end
    else
    begin
      beat_valid  <= emit;
      // upper bits stay fixed so the burst wraps inside its block
      beat_col    <= {block_reg[COL_W-1:BEAT_W], low_col};
      beat_active <= emit & slot_used;
      beat_dq_oe  <= emit & slot_used & ~wr_reg;
    end
  end

endmodule : sdram_mode_ctrl

/* rtl/sdram_mode_pkg.sv */
package sdram_mode_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int BA_W   = 3;
  localparam int MR_W   = 19;
  localparam int LAT_W  = 5;
  localparam int BEAT_W = 3;

  // ----------------------------------------------------------------
  // register select from bank address
  // ----------------------------------------------------------------
  localparam logic [BA_W-1:0] SEL_BASE = 3'h0;
  localparam logic [BA_W-1:0] SEL_MR1  = 3'h1;
  localparam logic [BA_W-1:0] SEL_MR2  = 3'h2;
  localparam logic [BA_W-1:0] SEL_MR3  = 3'h3;
  localparam int              OTHER_MRS = 3;

  // ----------------------------------------------------------------
  // base_mode_register field positions
  // ----------------------------------------------------------------
  localparam int BL_LO         = 0;
  localparam int BL_HI         = 1;
  localparam int LAT_EXT       = 2;
  localparam int ORDER_BIT     = 3;
  localparam int LAT_LO        = 4;
  localparam int LAT_HI        = 6;
  localparam int DLL_RST       = 8;
  localparam int WR_LO         = 9;
  localparam int WR_HI         = 11;
  localparam int PWRDN_DLL_BIT = 12;
  localparam int OTF_BIT       = 12;
  localparam logic [MR_W-1:0] BASE_RESET = 19'h00000;

  // ----------------------------------------------------------------
  // burst length codes
  // ----------------------------------------------------------------
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // ----------------------------------------------------------------
  // latency and timing
  // ----------------------------------------------------------------
  localparam logic [LAT_W-1:0] LAT_BASE    = 5'h04;
  localparam logic [LAT_W-1:0] LAT_EXT_ADD = 5'h08;
  localparam logic [LAT_W-1:0] LAT_MIN     = 5'h05;
  localparam logic [LAT_W-1:0] LAT_MAX     = 5'h0E;
  localparam int               DLLK_CYCLES    = 512;
  localparam int               MOD_CYCLES_DEF = 12;
  localparam int               WRITE_LAT_DEF  = 5;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 3'h7;
  localparam int               NIBBLE_BIT = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;

  typedef struct packed {
    logic [1:0]       burst_length;
    logic             burst_ordering_select;
    logic [LAT_W-1:0] read_latency_cycles;
    logic [LAT_W-1:0] write_recovery;
    logic             precharge_powerdown_dll;
  } mode_fields_t;

  function automatic logic [LAT_W-1:0] wr_decode(input logic [2:0] code);
    logic [LAT_W-1:0] r;
    r = 5'h10;
    case (code)
      3'h1: r = 5'h05;
      3'h2: r = 5'h06;
      3'h3: r = 5'h07;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0A;
      3'h6: r = 5'h0C;
      3'h7: r = 5'h0E;
      default: r = 5'h10;
    endcase
    return r;
  endfunction : wr_decode

  function automatic mode_fields_t decode_fields(input logic [MR_W-1:0] mr);
    mode_fields_t     f;
    logic [LAT_W-1:0] lat;
    lat = LAT_BASE + {2'h0, mr[LAT_HI:LAT_LO]} + (mr[LAT_EXT] ? LAT_EXT_ADD : 5'h00);
    if (lat < LAT_MIN)
      lat = LAT_MIN;
    else if (lat > LAT_MAX)
      lat = LAT_MAX;
    f.burst_length            = mr[BL_HI:BL_LO];
    f.burst_ordering_select   = mr[ORDER_BIT];
    f.read_latency_cycles     = lat;
    f.write_recovery          = wr_decode(mr[WR_HI:WR_LO]);
    f.precharge_powerdown_dll = mr[PWRDN_DLL_BIT];
    return f;
  endfunction : decode_fields

endpackage : sdram_mode_pkg

/* rtl/burst_col_order.sv */
`timescale 1ns/1ps
module burst_col_order
  import sdram_mode_pkg::*;
(
  // burst description
  input  wire logic [BEAT_W-1:0] start_col,
  input  wire logic              interleave,
  input  wire logic              is_write,
  input  wire logic              chop4,
  // beat
  input  wire logic [BEAT_W-1:0] beat,
  output logic      [BEAT_W-1:0] col
);

  logic [1:0] rot;

  assign rot = start_col[1:0] + beat[1:0];

  always_comb
  begin
    if (is_write)
    begin
      // writes ignore the low bits; chop keeps only the nibble select
      col = chop4 ? {start_col[NIBBLE_BIT], beat[1:0]} : beat;
    end
    else if (interleave)
    begin
      col = start_col ^ beat;
    end
    else
    begin
      col = {start_col[NIBBLE_BIT] ^ beat[NIBBLE_BIT], rot};
    end
  end

endmodule : burst_col_order

/* verif/sdram_mode_ctrl_checker.sv */
`timescale 1ns/1ps
module sdram_mode_ctrl_checker
  import sdram_mode_pkg::*;
#(
  parameter int MOD_CYCLES = MOD_CYCLES_DEF,
  parameter int COL_W      = 10
)
(
  // clock and reset
  input wire logic                             clk,
  input wire logic                             rst_n,
  // command pins
  input wire cmd_pins_t                        cmd_pins,
  // register state
  input wire logic [MR_W-1:0]                  base_mode_register,
  input wire logic [OTHER_MRS-1:0][ADDR_W-1:0] other_mode_registers,
  input wire mode_fields_t                     mode_fields,
  input wire logic                             settings_ready,
  // dll
  input wire logic                             dll_reset_pulse,
  input wire logic                             dll_locked,
  input wire logic                             dll_off_in_powerdown,
  // burst beats
  input wire logic                             beat_valid,
  input wire logic [COL_W-1:0]                 beat_col,
  input wire logic                             beat_active,
  input wire logic                             beat_dq_oe
);
  int busy_cnt;
  int lock_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // lengths of the pending-settings and dll-lock stretches
  always_ff @(posedge clk)
  begin
    busy_cnt <= (!rst_n || settings_ready) ? 0 : busy_cnt + 1;
  end

  always_ff @(posedge clk)
  begin
    lock_cnt <= (!rst_n || dll_locked) ? 0 : lock_cnt + 1;
  end

  a_update_len: assert property ($rose(settings_ready) |-> busy_cnt == MOD_CYCLES)
    else $error("update interval length wrong");
  a_fields_hold: assert property ($changed(mode_fields) |-> $rose(settings_ready))
    else $error("mode fields changed outside update end");
  a_bit_selfclr: assert property ($rose(base_mode_register[DLL_RST]) |->
    dll_reset_pulse ##1 !base_mode_register[DLL_RST])
    else $error("dll reset bit did not clear itself");
  a_lock_start: assert property (dll_reset_pulse |=> !dll_locked)
    else $error("dll reset did not start");
  a_lock_time: assert property ($rose(dll_locked) |-> lock_cnt >= 511 && lock_cnt <= 513)
    else $error("dll lock time wrong");
  // once settings are applied the power-down dll mode must follow the stored bit
  a_powerdown_dll: assert property (settings_ready |->
    dll_off_in_powerdown == !base_mode_register[PWRDN_DLL_BIT])
    else $error("power-down dll mode wrong");
  a_lat_range: assert property (mode_fields.read_latency_cycles >= LAT_MIN &&
    mode_fields.read_latency_cycles <= LAT_MAX)
    else $error("read latency out of range");
  a_burst_eight: assert property ($rose(beat_valid) |-> beat_valid[*8] ##1 !beat_valid)
    else $error("burst not eight slots");
  a_chop_head: assert property ($rose(beat_valid) |-> beat_active[*4])
    else $error("first four beats not active");
  a_chop_tail: assert property ($rose(beat_valid) ##4 !beat_active |->
    (beat_valid && !beat_active)[*4])
    else $error("chop tail not idle");
  a_oe_data: assert property (beat_dq_oe |-> beat_valid && beat_active)
    else $error("drivers on outside data beat");
  a_block_wrap: assert property (beat_valid && $past(beat_valid) |->
    $stable(beat_col[COL_W-1:3]))
    else $error("burst left its column block");
endmodule : sdram_mode_ctrl_checker

bind sdram_mode_ctrl sdram_mode_ctrl_checker #(.MOD_CYCLES(MOD_CYCLES), .COL_W(COL_W)) u_chk (
  .clk(clk), .rst_n(rst_n), .cmd_pins(cmd_pins), .base_mode_register(base_mode_register),
  .other_mode_registers(other_mode_registers), .mode_fields(mode_fields),
  .settings_ready(settings_ready), .dll_reset_pulse(dll_reset_pulse), .dll_locked(dll_locked),
  .dll_off_in_powerdown(dll_off_in_powerdown), .beat_valid(beat_valid), .beat_col(beat_col),
  .beat_active(beat_active), .beat_dq_oe(beat_dq_oe)
);

/* verif/ddr_ctrl_model.sv */
`timescale 1ns/1ps
module ddr_ctrl_model
  import sdram_mode_pkg::*;
#(
  parameter int MOD_CYCLES   = MOD_CYCLES_DEF,
  parameter int XPDLL_CYCLES = 10
)
(
  // clock
  input  wire logic clk,
  // command pins toward the device
  output cmd_pins_t cmd_pins
);
  logic        drive_reg = 1'b0;
  cmd_pins_t   cmd_reg   = '1;
  logic [21:0] noise_reg = 22'h2AAAAA;

  // deselected lines wander so the device never leans on stale levels
  always @(posedge clk)
  begin
    noise_reg <= ~noise_reg;
  end

  assign cmd_pins = drive_reg ? cmd_reg : {1'b1, noise_reg};

  // no odt, cke or calibration here: termination stays off, no power-down or supply switch
  task automatic send(input cmd_pins_t c);
    @(posedge clk);
    cmd_reg   <= c;
    drive_reg <= 1'b1;
    @(posedge clk);
    drive_reg <= 1'b0;
  endtask : send

  // banks are never opened, so every mode set finds them idle and precharged
  task automatic mrs(input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] v;
    v = a;
    if (ba == SEL_BASE)
    begin
      v[15:13] = 3'h0;
      v[7]     = 1'b0;
    end
    send({4'h0, ba, v});
    repeat (MOD_CYCLES + 3) @(posedge clk);
    if (ba == SEL_BASE)
      repeat (XPDLL_CYCLES) @(posedge clk);
    if (ba == SEL_BASE && v[DLL_RST])
      repeat (DLLK_CYCLES) @(posedge clk);
  endtask : mrs

  task automatic rw(input logic wr, input logic [ADDR_W-1:0] a);
    send({3'h2, ~wr, 3'h0, a});
  endtask : rw
endmodule : ddr_ctrl_model

/* verif/sdram_mode_ctrl_tb.sv */
`timescale 1ns/1ps
module sdram_mode_ctrl_tb;
  import sdram_mode_pkg::*;
  localparam int MODC = 12;
  localparam int COLW = 10;

  logic                             clk = 1'b0;
  logic                             rst_n = 1'b0;
  cmd_pins_t                        cmd_pins;
  logic [MR_W-1:0]                  base_mode_register;
  logic [OTHER_MRS-1:0][ADDR_W-1:0] other_mode_registers;
  mode_fields_t                     mode_fields;
  logic                             settings_ready;
  logic                             dll_reset_pulse;
  logic                             dll_locked;
  logic                             dll_off_in_powerdown;
  logic                             beat_valid;
  logic [COLW-1:0]                  beat_col;
  logic                             beat_active;
  logic                             beat_dq_oe;
  int                               n_fail = 0;
  int                               checks_done = 0;
  int                               cycles = 0;
  int                               m_bl = 0;
  int                               m_bt = 0;
  int                               m_lat = 5;
  int                               wrt[8] = '{16, 5, 6, 7, 8, 10, 12, 14};
  logic [31:0]                      rng = 32'h0000FDCA;

  always #5 clk = ~clk;

  sdram_mode_ctrl #(.MOD_CYCLES(MODC), .WRITE_LAT(WRITE_LAT_DEF), .COL_W(COLW)) dut (
    .clk(clk), .rst_n(rst_n), .cmd_pins(cmd_pins), .base_mode_register(base_mode_register),
    .other_mode_registers(other_mode_registers), .mode_fields(mode_fields),
    .settings_ready(settings_ready), .dll_reset_pulse(dll_reset_pulse), .dll_locked(dll_locked),
    .dll_off_in_powerdown(dll_off_in_powerdown), .beat_valid(beat_valid), .beat_col(beat_col),
    .beat_active(beat_active), .beat_dq_oe(beat_dq_oe)
  );

  ddr_ctrl_model #(.MOD_CYCLES(MODC)) model (.clk(clk), .cmd_pins(cmd_pins));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction : xs

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t register %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk_reg

  task automatic chk_beat(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t burst %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk_beat

  task automatic chk_reset();
    chk_reg(base_mode_register, 32'h0, "base");
    chk_reg(other_mode_registers[0] | other_mode_registers[1] | other_mode_registers[2], 32'h0,
      "others");
    chk_reg({settings_ready, dll_locked, mode_fields.burst_length}, 32'hC, "idle");
    chk_reg(mode_fields.read_latency_cycles, 32'h5, "latency");
    m_bl  = 0;
    m_bt  = 0;
    m_lat = 5;
  endtask : chk_reset

  task automatic set_mode(input int bl, input int bt, input int lat, input logic dll);
    logic [15:0] a;
    rng     = xs(rng);
    a       = 16'h0000;
    a[1:0]  = bl[1:0];
    a[3]    = bt[0];
    a[2]    = lat > 11;
    a[6:4]  = 3'(lat > 11 ? lat - 12 : lat - 4);
    a[8]    = dll;
    a[11:9] = 3'(1 + rng % 6);
    a[12]   = rng[8];
    model.mrs(3'h0, a);
    m_bl  = bl;
    m_bt  = bt;
    m_lat = lat;
    @(negedge clk);
    chk_reg(base_mode_register, {3'h0, a[15:9], 1'b0, a[7:0]}, "base");
    chk_reg({mode_fields.burst_length, mode_fields.burst_ordering_select}, {bl[1:0], bt[0]},
      "mode");
    chk_reg(mode_fields.read_latency_cycles, lat, "latency");
    chk_reg(mode_fields.write_recovery, wrt[a[11:9]], "recovery");
    chk_reg({dll_off_in_powerdown, settings_ready, dll_locked}, {~a[12], 2'h3}, "status");
  endtask : set_mode

  task automatic burst(input logic wr, input logic [2:0] s, input logic a12);
    logic [15:0] a;
    logic        chop;
    logic        act;
    int          n;
    int          e;
    rng  = xs(rng);
    a    = {3'h0, a12, 2'h0, rng[6:0], s};
    chop = (m_bl == 2) || (m_bl == 1 && !a12);
    model.rw(wr, a);
    n = 1;
    @(negedge clk);
    while (beat_valid !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk_beat(n, (wr ? WRITE_LAT_DEF : m_lat) + 2, "latency");
    for (int b = 0; b < 8; b++)
    begin
      act = !(chop && b > 3);
      if (wr)
        e = chop ? (s & 4) | (b & 3) : b;
      else if (m_bt == 1)
        e = s ^ b;
      else
        e = ((s ^ b) & 4) | ((s + b) & 3);
      chk_beat({beat_valid, beat_active, beat_dq_oe}, {1'b1, act, act & ~wr}, "flags");
      if (act)
        chk_beat(beat_col, {a[9:3], e[2:0]}, "column");
      @(negedge clk);
    end
    chk_beat(beat_valid, 32'h0, "end");
  endtask : burst

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk_reset();
    for (int bl = 0; bl < 3; bl++)
      for (int bt = 0; bt < 2; bt++)
      begin
        rng = xs(rng);
        set_mode(bl, bt, bl + bt == 0 ? 5 : (bl + bt == 3 ? 14 : 5 + rng % 10), 1'b0);
        for (int s = 0; s < 8; s++)
        begin
          burst(1'b0, s[2:0], s[0]);
          burst(1'b1, s[2:0], s[1]);
        end
      end
    // dll reset, then a read once lock time has passed
    set_mode(0, 0, 6, 1'b1);
    burst(1'b0, 3'h6, 1'b0);
    for (int r = 1; r < 4; r++)
    begin
      rng = xs(rng);
      model.mrs(r[2:0], rng[15:0]);
      @(negedge clk);
      chk_reg(other_mode_registers[r-1], rng[15:0], "other");
    end
    chk_reg(base_mode_register[6:4], 32'h2, "base kept");
    // second reset in mid-run must clear everything back to defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk_reset();
    burst(1'b0, 3'h5, 1'b0);
    conclude();
  end
endmodule : sdram_mode_ctrl_tb
